// file: common/cpm_pkg.sv
package cpm_pkg;

  // ----------------------------------------
  // System register coordinates
  // ----------------------------------------
  localparam logic [1:0] CPM_OP0 = 2'h3;
  localparam logic [2:0] CPM_OP1 = 3'h0;
  localparam logic [3:0] CPM_CRN = 4'hF;
  localparam logic [3:0] CPM_CRM_BANK = 4'h5;
  localparam logic [3:0] CPM_CRM_CYCLE = 4'h6;
  localparam logic [2:0] CPM_OP2_OVS_SET = 3'h3;
  localparam logic [2:0] CPM_OP2_OVS_CLR = 3'h4;
  localparam logic [2:0] CPM_OP2_SEL = 3'h5;
  localparam logic [2:0] CPM_OP2_INTEN_SET = 3'h6;
  localparam logic [2:0] CPM_OP2_INTEN_CLR = 3'h7;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int CPM_CYC_BIT = 31;
  localparam int CPM_EVT_MAX = 31;
  localparam int CPM_SEL_W = 5;
  localparam int CPM_AUX_WR_BIT = 12;
  localparam logic [31:0] CPM_ZERO32 = 32'h0000_0000;
  localparam logic [63:0] CPM_CYC_ONE = 64'h0000_0000_0000_0001;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {
    CPM_EL0,
    CPM_EL1,
    CPM_EL2,
    CPM_EL3
  } cpm_el_e;

  typedef struct packed {
    logic valid;
    logic write;
    cpm_el_e el;
    logic nonsecure;
    logic aux3_wr_en;
    logic aux2_wr_en;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
    logic [31:0] wdata;
  } cpm_req_s;

  typedef struct packed {
    logic valid;
    logic fault;
    logic [31:0] rdata;
  } cpm_rsp_s;

  typedef struct packed {
    logic rst_meta;
    logic rst_sync;
    logic [63:0] cycle_count;
    logic [31:0] ovf_flags;
    logic [31:0] irq_en;
    logic [CPM_SEL_W-1:0] sel;
    cpm_rsp_s rsp;
    logic irq;
  } cpm_state_s;

endpackage : cpm_pkg

// file: verilog/cpm_bank.sv
// Notes on behaviour
// - Overflow-clear bit 31 shows cycle overflow; writing 1 clears it, 0 leaves it.
// - Cycle overflow comes from bit 31 carry or full width, per long-cycle choice.
// - Overflow-clear bits 0..30 show event overflow flags; write 1 clears.
// - Bitmap bits from N up to 30 read zero and ignore writes.
// - Selection holds a 5-bit index in [4:0]; [31:5] read zero.
// - Index at or above N makes indirect accesses read zero, ignore writes.
// - Direct reads of the index may not show the written value.
// - Enable-set bit 31 shows cycle overflow irq enable; writing 1 enables.
// - Enable-set bits 0..30 show event overflow irq enables; write 1 enables.
// - Kernel writes need top aux bit 12 and hypervisor bit 12, or secure.
// - No user access; kernel, non-secure hypervisor and top levels may read and write.
// - Decode c15, c5, opcode1 0; opcode2 3 to 7 select the three registers.
// - Overflow-set write 1 sets the matching flag.
// - Enable-clear write 1 disables the matching irq enable.
// - Cycle counter increments every clock unless i_cycle_reset zeroes it; its overflow feeds flag 31.
module cpm_bank #(
  parameter int NUM_EVT = 6
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input cpm_pkg::cpm_req_s i_req,
  input wire logic i_long_cycle,
  input wire logic i_cycle_reset,
  input wire logic [cpm_pkg::CPM_EVT_MAX-1:0] i_evt_ovf,
  output cpm_pkg::cpm_rsp_s o_rsp,
  output logic [cpm_pkg::CPM_SEL_W-1:0] o_sel,
  output logic o_sel_valid,
  output logic [63:0] o_cycle_count,
  output logic o_irq
);
  import cpm_pkg::*;

  // ----------------------------------------
  // Masks and state
  // ----------------------------------------
  localparam logic [31:0] IMPL_MASK = {1'b1, {(31 - NUM_EVT){1'b0}}, {NUM_EVT{1'b1}}};

  cpm_state_s st_r;
  cpm_state_s st_nxt;
  logic [63:0] cyc_inc;
  logic cyc_ovf;
  logic hit;
  logic allowed;
  logic wr_ok;
  logic rd_ok;
  logic wr_ovs_clr;
  logic wr_ovs_set;
  logic wr_inten_set;
  logic wr_inten_clr;
  logic wr_sel;
  logic [31:0] wmask;
  logic [31:0] evt_set;
  logic sel_valid_r;
  logic sel_valid_nxt;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  always_comb begin
    hit = i_req.valid
      && i_req.op1 == CPM_OP1
      && i_req.crn == CPM_CRN
      && i_req.crm == CPM_CRM_BANK;
    unique case (i_req.el)
      CPM_EL0: begin
        allowed = 1'b0;
      end
      CPM_EL1: begin
        allowed = !i_req.write
          || (i_req.aux3_wr_en && (i_req.aux2_wr_en || !i_req.nonsecure));
      end
      CPM_EL2: begin
        allowed = i_req.nonsecure;
      end
      CPM_EL3: begin
        allowed = 1'b1;
      end
    endcase
    wr_ok = hit && allowed && i_req.write;
    rd_ok = hit && allowed && !i_req.write;
    wr_ovs_clr = wr_ok && i_req.op2 == CPM_OP2_OVS_CLR;
    wr_ovs_set = wr_ok && i_req.op2 == CPM_OP2_OVS_SET;
    wr_inten_set = wr_ok && i_req.op2 == CPM_OP2_INTEN_SET;
    wr_inten_clr = wr_ok && i_req.op2 == CPM_OP2_INTEN_CLR;
    wr_sel = wr_ok && i_req.op2 == CPM_OP2_SEL;
    wmask = i_req.wdata & IMPL_MASK;
    evt_set = {1'b0, i_evt_ovf} & IMPL_MASK;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.rst_meta = 1'b1;
    st_nxt.rst_sync = st_r.rst_meta;
    // Cycle counter
    cyc_inc = st_r.cycle_count + CPM_CYC_ONE;
    cyc_ovf = i_long_cycle ? (&st_r.cycle_count) : (&st_r.cycle_count[CPM_CYC_BIT:0]);
    if (i_cycle_reset) begin
      st_nxt.cycle_count = '0;
    end else begin
      st_nxt.cycle_count = cyc_inc;
    end
    // Overflow flags; a hardware set wins over a clear in the same cycle
    if (wr_ovs_clr) begin
      st_nxt.ovf_flags = st_r.ovf_flags & ~wmask;
    end else if (wr_ovs_set) begin
      st_nxt.ovf_flags = st_r.ovf_flags | wmask;
    end
    st_nxt.ovf_flags = st_nxt.ovf_flags | evt_set;
    st_nxt.ovf_flags[CPM_CYC_BIT] = st_nxt.ovf_flags[CPM_CYC_BIT] | cyc_ovf;
    st_nxt.ovf_flags = st_nxt.ovf_flags & IMPL_MASK;
    // Interrupt enables
    if (wr_inten_set) begin
      st_nxt.irq_en = st_r.irq_en | wmask;
    end else if (wr_inten_clr) begin
      st_nxt.irq_en = st_r.irq_en & ~wmask;
    end
    // Counter select
    if (wr_sel) begin
      st_nxt.sel = i_req.wdata[CPM_SEL_W-1:0];
    end
    // Read response
    st_nxt.rsp.valid = i_req.valid;
    st_nxt.rsp.fault = i_req.valid && !(hit && allowed);
    st_nxt.rsp.rdata = CPM_ZERO32;
    if (rd_ok) begin
      unique case (i_req.op2)
        CPM_OP2_OVS_CLR, CPM_OP2_OVS_SET: begin
          st_nxt.rsp.rdata = st_r.ovf_flags & IMPL_MASK;
        end
        CPM_OP2_INTEN_SET, CPM_OP2_INTEN_CLR: begin
          st_nxt.rsp.rdata = st_r.irq_en & IMPL_MASK;
        end
        CPM_OP2_SEL: begin
          st_nxt.rsp.rdata = {{(32 - CPM_SEL_W){1'b0}}, st_r.sel};
        end
        default: begin
          st_nxt.rsp.rdata = CPM_ZERO32;
        end
      endcase
    end
    // Interrupt request
    st_nxt.irq = |(st_nxt.ovf_flags & st_nxt.irq_en & IMPL_MASK);
    // Hold all but the release flops at rest until reset is released
    if (!st_r.rst_sync) begin
      st_nxt.cycle_count = '0;
      st_nxt.ovf_flags = CPM_ZERO32;
      st_nxt.irq_en = CPM_ZERO32;
      st_nxt.sel = '0;
      st_nxt.rsp = '0;
      st_nxt.irq = 1'b0;
    end
    sel_valid_nxt = st_r.rst_sync && (32'(st_nxt.sel) < 32'(NUM_EVT));
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
      sel_valid_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      sel_valid_r <= sel_valid_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------

  assign o_rsp = st_r.rsp;
  assign o_sel = st_r.sel;
  assign o_sel_valid = sel_valid_r;
  assign o_cycle_count = st_r.cycle_count;
  assign o_irq = st_r.irq;

endmodule : cpm_bank

// file: tb/cpm_bank_asserts.sv
module cpm_bank_asserts #(
  parameter int NUM_EVT = 6
) (
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_cycle_reset,
  input cpm_pkg::cpm_req_s i_req,
  input cpm_pkg::cpm_rsp_s o_rsp,
  input wire logic [4:0] o_sel,
  input wire logic o_sel_valid,
  input wire logic [63:0] o_cycle_count
);
  timeunit 1ns;
  timeprecision 100ps;
  import cpm_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic wr3 = i_req.valid && i_req.write && i_req.el == CPM_EL3 && i_req.crn == CPM_CRN
    && i_req.op1 == CPM_OP1 && i_req.crm == CPM_CRM_BANK;
  rsp_on_time_a: assert property (i_req.valid |=> o_rsp.valid) else $error("late rsp");
  rsp_quiet_a: assert property (!i_req.valid |=> !o_rsp.valid) else $error("stray rsp");
  user_block_a: assert property (i_req.valid && i_req.el == CPM_EL0 |=> o_rsp.fault)
    else $error("user access");
  kernel_wr_a: assert property (i_req.valid && i_req.write && i_req.el == CPM_EL1 &&
    !(i_req.aux3_wr_en && (i_req.aux2_wr_en || !i_req.nonsecure)) |=> o_rsp.fault) else $error("kernel write");
  sel_range_a: assert property (o_sel >= NUM_EVT |-> !o_sel_valid) else $error("bad select");
  sel_load_a: assert property (wr3 && i_req.op2 == CPM_OP2_SEL |=> o_sel == $past(i_req.wdata[4:0]))
    else $error("select load");
  cyc_step_a: assert property (o_cycle_count != 0 && !i_cycle_reset |=>
    o_cycle_count == $past(o_cycle_count) + CPM_CYC_ONE) else $error("cycle step");
  map_zero_a: assert property (o_rsp.valid |-> o_rsp.rdata[30:NUM_EVT] == '0) else $error("bitmap");
endmodule : cpm_bank_asserts

bind cpm_bank cpm_bank_asserts #(.NUM_EVT(NUM_EVT)) cpm_bank_asserts_inst (.i_clk(i_clk), .i_nrst(i_nrst),
  .i_cycle_reset(i_cycle_reset), .i_req(i_req), .o_rsp(o_rsp), .o_sel(o_sel), .o_sel_valid(o_sel_valid),
  .o_cycle_count(o_cycle_count));

// file: tb/cpm_core_model.sv
module cpm_core_model (
  input wire logic i_clk,
  input cpm_pkg::cpm_rsp_s i_rsp,
  output cpm_pkg::cpm_req_s o_req
);
  timeunit 1ns;
  timeprecision 100ps;
  import cpm_pkg::*;
  initial o_req = '0;
  // One-cycle request after an edge; data line inverted once released
  task automatic acc(input cpm_el_e el, input logic [2:0] ctl, input logic [3:0] crn, input logic wr,
    input logic [2:0] op2, input logic [31:0] wd, output logic [32:0] rsp);
    @(posedge i_clk);
    #1 o_req = '{1'b1, wr, el, ctl[2], ctl[1], ctl[0], CPM_OP1, crn, CPM_CRM_BANK, op2, wd};
    @(posedge i_clk);
    #1 o_req.valid = 1'b0;
    o_req.wdata = ~wd;
    rsp = {i_rsp.fault, i_rsp.rdata};
  endtask : acc
endmodule : cpm_core_model

// file: tb/test_cluster_pmu_overflow_select_inten.sv
module test_cluster_pmu_overflow_select_inten;
  timeunit 1ns;
  timeprecision 100ps;
  import cpm_pkg::*;
  localparam int NE = 6;
  localparam logic [31:0] EVM = (32'h1 << NE) - 32'h1;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [30:0] evt = '0;
  logic cyc_rst = 1'b0;
  cpm_req_s req;
  cpm_rsp_s rsp;
  logic [4:0] sel;
  logic sel_ok;
  logic irq;
  logic [63:0] cyc;
  logic [32:0] r;
  int err_count = 0;
  int cmp_count = 0;
  always #2.5 i_clk = ~i_clk;
  cpm_bank #(.NUM_EVT(NE)) cpm_bank_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_req(req), .i_long_cycle(1'b0),
    .i_cycle_reset(cyc_rst), .i_evt_ovf(evt), .o_rsp(rsp), .o_sel(sel), .o_sel_valid(sel_ok),
    .o_cycle_count(cyc), .o_irq(irq));
  cpm_core_model cpm_core_model_inst (.i_clk(i_clk), .i_rsp(rsp), .o_req(req));
  task automatic chk(input string nm, input logic [32:0] e, input logic [32:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rw(input logic wr, input logic [2:0] op2, input logic [31:0] wd, input logic [31:0] e);
    cpm_core_model_inst.acc(CPM_EL3, 3'b111, CPM_CRN, wr, op2, wd, r);
    chk("fault", 33'h0, {32'h0, r[32]});
    if (!wr) chk("rdata", {1'b0, e}, r);
  endtask : rw
  task automatic deny(input cpm_el_e el, input logic [2:0] ctl, input logic [3:0] crn, input logic wr);
    cpm_core_model_inst.acc(el, ctl, crn, wr, CPM_OP2_INTEN_SET, 32'hFFFF_FFFF, r);
    chk("refused", 33'h1_0000_0000, r);
  endtask : deny
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out
  initial begin
    #20000;
    err_count++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge i_clk);
    #1 i_nrst = 1'b1;
    repeat (3) @(posedge i_clk);
    rw(1, CPM_OP2_INTEN_SET, 32'hFFFF_FFFF, 0);
    rw(0, CPM_OP2_INTEN_SET, 0, EVM | 32'h8000_0000);
    @(posedge i_clk) #1 evt = '1;
    @(posedge i_clk) #1 evt = '0;
    rw(0, CPM_OP2_OVS_CLR, 0, EVM);
    chk("irq", 33'h1, {32'h0, irq});
    rw(1, CPM_OP2_OVS_CLR, 32'h0000_0001, 0);
    rw(1, CPM_OP2_OVS_SET, 32'h8000_0000, 0);
    rw(0, CPM_OP2_OVS_CLR, 0, (EVM - 32'h1) | 32'h8000_0000);
    rw(1, CPM_OP2_OVS_CLR, 32'h8000_0000, 0);
    rw(0, CPM_OP2_OVS_CLR, 0, EVM - 32'h1);
    rw(1, CPM_OP2_INTEN_CLR, 32'hFFFF_FFFF, 0);
    rw(0, CPM_OP2_INTEN_SET, 0, 0);
    chk("irq", 33'h0, {32'h0, irq});
    $display("test bitmaps done");
    deny(CPM_EL0, 3'b011, CPM_CRN, 0);
    deny(CPM_EL1, 3'b101, CPM_CRN, 1);
    deny(CPM_EL1, 3'b110, CPM_CRN, 1);
    deny(CPM_EL3, 3'b011, 4'hE, 0);
    cpm_core_model_inst.acc(CPM_EL1, 3'b010, CPM_CRN, 1, CPM_OP2_INTEN_SET, 32'h1, r);
    chk("kernel write", 33'h0, {32'h0, r[32]});
    rw(0, CPM_OP2_INTEN_SET, 0, 32'h1);
    $display("test access done");
    rw(1, CPM_OP2_SEL, 32'h0000_0007, 0);
    chk("sel_valid", 33'h0, {32'h0, sel_ok});
    rw(1, CPM_OP2_SEL, 32'(NE - 1), 0);
    chk("sel", {27'h0, 1'b1, 5'(NE - 1)}, {27'h0, sel_ok, sel});
    r = {1'b0, cyc[31:0]};
    @(posedge i_clk) #1 chk("cycles", r + 33'h1, {1'b0, cyc[31:0]});
    @(posedge i_clk) #1 cyc_rst = 1'b1;
    @(posedge i_clk) #1 cyc_rst = 1'b0;
    chk("cycle reset", 33'h0, {1'b0, cyc[31:0]});
    $display("test select done");
    close_out();
  end
endmodule : test_cluster_pmu_overflow_select_inten
